// [design/rpt_consts.svh]
// constants for the rgb panel timing controller
`ifndef RPT_CONSTS_SVH
`define RPT_CONSTS_SVH
`define RPT_PIX_DIV_DEF   8'h04
`define RPT_H_FP_DEF      12'h008
`define RPT_H_SYNC_DEF    12'h004
`define RPT_H_BP_DEF      12'h010
`define RPT_H_ACT_DEF     12'h140
`define RPT_V_FP_DEF      12'h002
`define RPT_V_SYNC_DEF    12'h002
`define RPT_V_BP_DEF      12'h004
`define RPT_V_ACT_DEF     12'h0F0
`define RPT_CW            12
`endif

// [design/rpt_pkg.sv]
// types for the rgb panel timing controller
package rpt_pkg;
  typedef enum logic [1:0] {
    RPT_ST_SYNC  = 2'b00,
    RPT_ST_BACK  = 2'b01,
    RPT_ST_ACT   = 2'b11,
    RPT_ST_FRONT = 2'b10
  } rpt_phase_t;
endpackage

// [design/rpt_sync2.sv]
// two-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module rpt_sync2 (
  input  wire logic i_clk,
  input  wire logic i_ce,
  input  wire logic i_d,
  output var  logic o_q
);
  logic meta_reg;
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule // rpt_sync2
`default_nettype wire

// [design/rpt_phase_cnt.sv]
// one axis counter walking sync, back porch, active and front porch
`timescale 1ns/1ps
`default_nettype none
module rpt_phase_cnt #(
  parameter int W = 12
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_step,
  input  wire logic [W-1:0]    i_sync,
  input  wire logic [W-1:0]    i_back,
  input  wire logic [W-1:0]    i_act,
  input  wire logic [W-1:0]    i_front,
  output var  rpt_pkg::rpt_phase_t o_phase,
  output var  logic [W-1:0]    o_pos,
  output var  logic            o_wrap
);
  logic [W-1:0] len;
  always_comb begin
    case (o_phase)
      rpt_pkg::RPT_ST_SYNC:  len = i_sync;
      rpt_pkg::RPT_ST_BACK:  len = i_back;
      rpt_pkg::RPT_ST_ACT:   len = i_act;
      rpt_pkg::RPT_ST_FRONT: len = i_front;
      default:               len = i_sync;
    endcase
  end
  wire logic last = (o_pos + W'(1) >= len);
  assign o_wrap = i_step && last && (o_phase == rpt_pkg::RPT_ST_FRONT);
  // each phase length is a runtime count
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_phase <= rpt_pkg::RPT_ST_SYNC;
      o_pos   <= '0;
    end else if (i_step) begin
      if (last) begin
        o_pos <= '0;
        case (o_phase)
          rpt_pkg::RPT_ST_SYNC:  o_phase <= rpt_pkg::RPT_ST_BACK;
          rpt_pkg::RPT_ST_BACK:  o_phase <= rpt_pkg::RPT_ST_ACT;
          rpt_pkg::RPT_ST_ACT:   o_phase <= rpt_pkg::RPT_ST_FRONT;
          default:               o_phase <= rpt_pkg::RPT_ST_SYNC;
        endcase
      end else begin
        o_pos <= o_pos + W'(1);
      end
    end
  end
endmodule // rpt_phase_cnt
`default_nettype wire

// [design/rpt_panel_ctrl.sv]
// rgb panel raster controller: pixel clock, syncs, enable and pixel bus
`include "rpt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module rpt_panel_ctrl #(
  parameter int CW = `RPT_CW
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_ce,
  input  wire logic          i_start,
  input  wire logic          i_stop,
  input  wire logic [31:0]   i_base_addr,
  input  wire logic [7:0]    i_pix_div,
  input  wire logic [CW-1:0] i_h_sync,
  input  wire logic [CW-1:0] i_h_back,
  input  wire logic [CW-1:0] i_h_act,
  input  wire logic [CW-1:0] i_h_front,
  input  wire logic [CW-1:0] i_v_sync,
  input  wire logic [CW-1:0] i_v_back,
  input  wire logic [CW-1:0] i_v_act,
  input  wire logic [CW-1:0] i_v_front,
  input  wire logic          i_mirror_h,
  input  wire logic          i_mirror_v,
  input  wire logic          i_fall_edge,
  input  wire logic          i_en_hold,
  input  wire logic [15:0]   i_pix_data,
  input  wire logic          i_pix_valid,
  input  wire logic          i_vsync_in,
  output logic               o_pix_ready,
  output logic               o_run,
  output logic               o_addr_err,
  output logic               o_line_done,
  output logic               o_mcu_window,
  output logic               o_pixel_clock_out,
  output logic               o_line_sync_n,
  output logic               o_frame_sync_n,
  output logic               o_pixel_valid_enable,
  output logic [7:0]         o_red,
  output logic [7:0]         o_green,
  output logic [7:0]         o_blue,
  output logic               o_mirror_h,
  output logic               o_mirror_v
);
  // ==========================================================
  // run control
  logic run_reg;
  logic vsync_in_s;
  rpt_sync2 u_vs (
    .i_clk (i_clk),
    .i_ce  (i_ce),
    .i_d   (i_vsync_in),
    .o_q   (vsync_in_s)
  );
  // odd base refused, runs until stopped
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run_reg    <= 1'b0;
      o_addr_err <= 1'b0;
    end else if (i_ce) begin
      if (i_start && i_base_addr[0]) begin
        o_addr_err <= 1'b1;
      end else if (i_start) begin
        o_addr_err <= 1'b0;
        run_reg    <= 1'b1;
      end else if (i_stop) begin
        run_reg    <= 1'b0;
      end
    end
  end
  // ==========================================================
  // pixel clock divider: one common time base for all timing
  logic [7:0] div_reg;
  logic       tick;
  logic       half;
  assign tick = i_ce && run_reg && (div_reg == 8'h00);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !run_reg) begin
      div_reg <= 8'h00;
    end else if (i_ce) begin
      div_reg <= (div_reg + 8'h01 >= i_pix_div) ? 8'h00 : div_reg + 8'h01;
    end
  end
  assign half = (div_reg < (i_pix_div >> 1));
  // ==========================================================
  // horizontal and vertical counters
  rpt_pkg::rpt_phase_t hph;
  rpt_pkg::rpt_phase_t vph;
  logic [CW-1:0] hpos;
  logic [CW-1:0] vpos;
  logic          hwrap;
  logic          vwrap;
  logic          hstep;
  logic          vstep;
  assign vstep = hwrap;
  // the line advances only when a pixel word is present in the visible area (both axes active)
  assign hstep = tick && ((hph != rpt_pkg::RPT_ST_ACT) || (vph != rpt_pkg::RPT_ST_ACT)
                          || i_pix_valid);
  rpt_phase_cnt #(.W(CW)) u_h (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n && run_reg),
    .i_step  (hstep),
    .i_sync  (i_h_sync),
    .i_back  (i_h_back),
    .i_act   (i_h_act),
    .i_front (i_h_front),
    .o_phase (hph),
    .o_pos   (hpos),
    .o_wrap  (hwrap)
  );
  rpt_phase_cnt #(.W(CW)) u_v (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n && run_reg),
    .i_step  (vstep),
    .i_sync  (i_v_sync),
    .i_back  (i_v_back),
    .i_act   (i_v_act),
    .i_front (i_v_front),
    .o_phase (vph),
    .o_pos   (vpos),
    .o_wrap  (vwrap)
  );
  logic visible;
  assign visible = (hph == rpt_pkg::RPT_ST_ACT) && (vph == rpt_pkg::RPT_ST_ACT);
  assign o_pix_ready = hstep && visible;
  // ==========================================================
  // panel outputs, all registered
  logic gate_reg;
  logic gate_now;
  // use the slot's own gate from its first cycle, else a stalled slot inherits a half pulse
  assign gate_now = tick ? !(visible && !i_pix_valid) : gate_reg;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_line_sync_n        <= 1'b1;
      o_frame_sync_n       <= 1'b1;
      o_pixel_valid_enable <= 1'b0;
      o_pixel_clock_out    <= 1'b0;
      o_red                <= 8'h00;
      o_green              <= 8'h00;
      o_blue               <= 8'h00;
      o_line_done          <= 1'b0;
      o_mcu_window         <= 1'b0;
      o_run                <= 1'b0;
      gate_reg             <= 1'b0;
      o_mirror_h           <= 1'b0;
      o_mirror_v           <= 1'b0;
    end else if (i_ce) begin
      o_run        <= run_reg;
      o_mirror_h   <= i_mirror_h;
      o_mirror_v   <= i_mirror_v;
      o_line_sync_n  <= !(run_reg && hph == rpt_pkg::RPT_ST_SYNC);
      o_frame_sync_n <= !(run_reg && vph == rpt_pkg::RPT_ST_SYNC
                          && !vsync_in_s);
      o_pixel_valid_enable <= i_en_hold ? 1'b1 : (run_reg && visible);
      o_line_done  <= hstep && (hph == rpt_pkg::RPT_ST_ACT)
                      && (hpos + CW'(1) >= i_h_act) && (vph == rpt_pkg::RPT_ST_ACT);
      o_mcu_window <= run_reg && (vph != rpt_pkg::RPT_ST_ACT);
      if (tick) gate_reg <= gate_now;
      // low phase after data launch gives a rising edge mid-pixel (high phase and a falling edge with i_fall_edge)
      o_pixel_clock_out <= run_reg && gate_now && (half ^ !i_fall_edge);
      if (o_pix_ready) begin
        o_red   <= {i_pix_data[15:11], i_pix_data[15:13]};
        o_green <= {i_pix_data[10:5],  i_pix_data[10:9]};
        o_blue  <= {i_pix_data[4:0],   i_pix_data[4:2]};
      end
    end
  end
  // ==========================================================
  // checks
  chk_sync_low_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !run_reg |=> o_line_sync_n) else $error("line sync active while idle");
  chk_odd_norun: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_start && i_base_addr[0] && !run_reg |=> !run_reg) else $error("odd base ran");
  chk_odd_base: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_start && i_base_addr[0] |=> o_addr_err) else $error("odd base accepted");
  chk_enable_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !i_en_hold && !visible |=> !o_pixel_valid_enable) else $error("enable out");
  chk_strap_h: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce |=> o_mirror_h == $past(i_mirror_h)) else $error("h strap");
  chk_strap_v: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce |=> o_mirror_v == $past(i_mirror_v)) else $error("v strap");
  cov_line: cover property (@(posedge i_clk) o_line_done);
  cov_frame: cover property (@(posedge i_clk) !o_frame_sync_n);
  cov_err: cover property (@(posedge i_clk) o_addr_err);
endmodule // rpt_panel_ctrl
`default_nettype wire

// [dv/rpt_panel_model.sv]
// behavioural rgb panel: takes colour on its active clock edge and counts lines
`timescale 1ns/1ps
`default_nettype none
module rpt_panel_model (
  input  wire logic        i_pclk,
  input  wire logic        i_fall,
  input  wire logic        i_hs_n,
  input  wire logic        i_vs_n,
  input  wire logic        i_en,
  input  wire logic [23:0] i_rgb,
  input  wire logic        i_mh,
  input  wire logic        i_mv,
  output var  logic [23:0] o_rgb,
  output var  logic [1:0]  o_scan,
  output var  int          o_words,
  output var  int          o_lines,
  output var  int          o_line_pix
);
  // ======
  // panel sampling
  int  w0 = 0;
  wire edge_clk = i_pclk ^ i_fall;
  initial begin
    o_words = 0;
    o_lines = 0;
    o_line_pix = 0;
  end
  // one word per edge, and only while the enable is high
  always @(posedge edge_clk) begin
    if (i_en === 1'b1) begin
      o_rgb <= i_rgb;
      o_words <= o_words + 1;
    end
  end
  // a line closes at falling line sync; blank lines carry no pixels
  always @(negedge i_hs_n) begin
    if (o_words != w0) begin
      o_line_pix <= o_words - w0;
      o_lines <= o_lines + 1;
    end
    w0 <= o_words;
  end
  always @(negedge i_vs_n) o_scan <= {i_mv, i_mh};
endmodule // rpt_panel_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the rgb panel raster controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ======
  // stimulus and observation
  localparam int DIV = 4;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_start = 1'b0;
  logic        i_stop = 1'b0;
  logic        i_mirror_h = 1'b0;
  logic        i_mirror_v = 1'b0;
  logic        i_fall_edge = 1'b0;
  logic        i_en_hold = 1'b0;
  logic        i_pix_valid = 1'b1;
  logic [31:0] i_base_addr = 32'h0;
  logic [15:0] i_pix_data = 16'h0;
  logic [11:0] i_h_sync = 12'h2, i_h_back = 12'h3, i_h_act = 12'h8, i_h_front = 12'h2;
  logic [11:0] i_v_sync = 12'h2, i_v_back = 12'h1, i_v_act = 12'h3, i_v_front = 12'h1;
  logic        o_pix_ready, o_run, o_addr_err, o_line_done, o_mcu_window, o_pixel_clock_out;
  logic        o_line_sync_n, o_frame_sync_n, o_pixel_valid_enable, o_mirror_h, o_mirror_v;
  logic [7:0]  o_red, o_green, o_blue;
  logic [23:0] m_rgb;
  logic [1:0]  m_scan;
  int          m_words, m_lines, m_lpix, n_errors = 0, num_checks = 0;
  int          hlow = 0, vlow = 0, nld = 0, l0 = 0, d0 = 0;
  logic        arm = 1'b0, meas = 1'b0;
  logic [31:0] seed = 32'hD0798DC1;
  logic [15:0] q[$];
  logic [15:0] wq;

  rpt_panel_ctrl dut (
    .i_clk, .i_rst_n, .i_ce(1'b1), .i_start, .i_stop, .i_base_addr, .i_pix_div(8'(DIV)),
    .i_h_sync, .i_h_back, .i_h_act, .i_h_front, .i_v_sync, .i_v_back, .i_v_act, .i_v_front,
    .i_mirror_h, .i_mirror_v, .i_fall_edge, .i_en_hold, .i_pix_data, .i_pix_valid,
    .i_vsync_in(1'b0), .o_pix_ready, .o_run, .o_addr_err, .o_line_done, .o_mcu_window,
    .o_pixel_clock_out, .o_line_sync_n, .o_frame_sync_n, .o_pixel_valid_enable,
    .o_red, .o_green, .o_blue, .o_mirror_h, .o_mirror_v);
  rpt_panel_model pm (
    .i_pclk(o_pixel_clock_out), .i_fall(i_fall_edge), .i_hs_n(o_line_sync_n),
    .i_vs_n(o_frame_sync_n), .i_en(o_pixel_valid_enable), .i_rgb({o_red, o_green, o_blue}),
    .i_mh(o_mirror_h), .i_mv(o_mirror_v), .o_rgb(m_rgb), .o_scan(m_scan),
    .o_words(m_words), .o_lines(m_lines), .o_line_pix(m_lpix));

  always #5 i_clk = ~i_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [23:0] exp_rgb(input logic [15:0] d);
    return {d[15:11], d[15:13], d[10:5], d[10:9], d[4:0], d[4:2]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    num_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %0h want %0h", $time, what, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_run(input logic want);
    for (int i = 0; i < 4000 && o_run !== want; i++) @(negedge i_clk);
  endtask

  // ======
  // monitors
  always @(negedge i_clk) begin
    seed = xs(seed);
    i_pix_data <= seed[15:0];
    i_pix_valid <= seed[16] | seed[17];
  end
  always @(posedge i_clk) if (o_pix_ready === 1'b1) q.push_back(i_pix_data);
  always @(m_words) begin
    if (q.size() > 0) begin
      wq = q.pop_front();
      if (arm && !i_en_hold) check(m_rgb, exp_rgb(wq), "colour");
    end else if (arm && !i_en_hold) check(32'h0, 32'h1, "pixel with no word");
  end
  always @(m_lines) if (arm && !i_en_hold) check(m_lpix, i_h_act, "pixels per line");
  always @(posedge i_clk) begin
    hlow <= o_line_sync_n ? 0 : hlow + 1;
    vlow <= o_frame_sync_n ? 0 : vlow + 1;
    if (o_line_done === 1'b1) nld <= nld + 1;
    if (arm && o_line_sync_n && hlow > 0) check(hlow, i_h_sync * DIV, "hsync width");
    if (arm && o_frame_sync_n && vlow > 0) check(vlow,
      i_v_sync * (i_h_sync + i_h_back + i_h_act + i_h_front) * DIV, "vsync width");
    if (arm && i_en_hold) check(o_pixel_valid_enable, 1'b1, "enable held");
    if (arm && o_pixel_valid_enable && !i_en_hold) check(o_mcu_window, 1'b0, "cpu window");
  end
  always @(negedge o_frame_sync_n) begin
    if (arm && !i_en_hold) check(m_lines - l0, i_v_act, "lines per frame");
    if (arm) check(nld - d0, i_v_act, "line events");
    if (arm) check(m_scan, {i_mirror_v, i_mirror_h}, "scan straps");
    l0 = m_lines;
    d0 = nld;
    arm = meas;
  end

  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk) i_rst_n = 1'b1;
    check({o_run, o_addr_err, o_pixel_valid_enable, o_frame_sync_n, o_line_sync_n}, 5'h03,
          "reset state");
    @(negedge i_clk) {i_base_addr, i_start} = {32'h00001001, 1'b1};
    @(negedge i_clk) i_start = 1'b0;
    repeat (3) @(negedge i_clk);
    check({o_addr_err, o_run}, 2'b10, "odd base");
    for (int k = 0; k < 4; k++) begin
      @(negedge i_clk);
      i_h_act = 12'h8 + 12'(seed[2:0]);
      i_v_act = 12'h3 + 12'(seed[4:3]);
      {i_mirror_v, i_mirror_h} = 2'(k);
      i_fall_edge = (k == 2);
      i_en_hold = (k == 3);
      {i_base_addr, i_start} = {seed[31:1], 1'b0, 1'b1};
      @(negedge i_clk) i_start = 1'b0;
      wait_run(1'b1);
      check({o_run, o_addr_err}, 2'b10, "run after start");
      check({o_mirror_v, o_mirror_h}, {i_mirror_v, i_mirror_h}, "strap copies");
      meas = 1'b1;
      repeat (3) @(negedge o_frame_sync_n);
      {meas, arm} = 2'b00;
      @(negedge i_clk) i_stop = 1'b1;
      @(negedge i_clk) i_stop = 1'b0;
      wait_run(1'b0);
      check(o_run, 1'b0, "stop");
      repeat (DIV * 4) @(negedge i_clk);
      q.delete();
    end
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
